// file: decel_ramp.sv
`timescale 1ns/1ps
module decel_ramp
    import stop_seq_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [15:0] start_speed,
    input  wire logic        run,
    input  wire logic [15:0] time_ms,
    input  wire logic [15:0] rated_speed,
    output logic      [15:0] speed,
    output logic             at_zero
);
    // The speed falls by rated_speed per time_ms, so a ramp from speed s lasts
    // time_ms * s / rated_speed. The time is read live while ramping.
    logic [15:0] speed_ff;
    logic [31:0] acc_ff;
    logic [31:0] span;
    logic [31:0] acc_sum;

    assign span    = 32'(time_ms) * 32'(CYCLES_PER_MS);
    assign acc_sum = acc_ff + 32'(rated_speed);
    assign speed   = speed_ff;
    assign at_zero = (speed_ff == 16'h0000);

    always_ff @(posedge clock) begin
        if (rst) begin
            speed_ff <= 16'h0000;
            acc_ff   <= 32'h0000_0000;
        end else if (load) begin
            speed_ff <= start_speed;
            acc_ff   <= 32'h0000_0000;
        end else if (run && !at_zero) begin
            if (time_ms == 16'h0000) begin
                speed_ff <= 16'h0000;
            end else if (acc_sum >= span) begin
                acc_ff   <= acc_sum - span;
                speed_ff <= speed_ff - 16'h0001;
            end else begin
                acc_ff <= acc_sum;
            end
        end
    end

endmodule // decel_ramp

// file: motor_stage_model.sv
`timescale 1ns/1ps
module motor_stage_model
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        motor_power,
    input  wire logic        speed_override,
    input  wire logic [15:0] speed_ref,
    input  wire logic        brake_active,
    input  wire logic [15:0] user_speed,
    input  wire logic        user_enable,
    output logic      [15:0] speed_fb,
    output logic             enable_in
);
    logic friction_ff;

    assign enable_in = user_enable;

    // The motor follows the ramp by at most one step a clock and coasts down slowly unpowered.
    always_ff @(posedge clock) begin
        if (rst) begin
            speed_fb    <= 16'h0000;
            friction_ff <= 1'b0;
        end else begin
            friction_ff <= ~friction_ff;
            if (brake_active) begin
                if (speed_fb != 16'h0000) speed_fb <= speed_fb - 16'h0001;
            end else if (motor_power && speed_override) begin
                if (speed_fb > speed_ref) speed_fb <= speed_fb - 16'h0001;
            end else if (motor_power) begin
                speed_fb <= user_speed;
            end else if (friction_ff && speed_fb != 16'h0000) begin
                speed_fb <= speed_fb - 16'h0001;
            end
        end
    end
endmodule // motor_stage_model

// file: servo_fault_stop_sequencer.sv
`timescale 1ns/1ps
// Overview of operation
// - Class one faults cut power and coast
// - Class two faults use class two mode
// - Class three faults use class three mode
// - Over-travel uses its own stop mode
// - Mode zero drops output, motor coasts
// - Mode one: fast ramp, then disable
// - Mode two: slow ramp, then disable
// - Mode three: fast ramp, hold until unenabled
// - Mode four: slow ramp, hold until unenabled
// - Mode five brakes with set current
// - Motor stays energised during any ramp
// - Fast time, default 500 ms, live
// - Slow time, default 1000 ms, live
// - Ramp time scales with speed at fault
// - Mode settings accept 0-5, reset 0
module servo_fault_stop_sequencer
    import stop_seq_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        fault_valid,
    input  wire logic [9:0]  fault_code,
    input  wire logic        overtravel,
    input  wire logic [15:0] speed_fb,
    input  wire logic        enable_in,
    input  wire logic        fault_clear,
    output logic             motor_power,
    output logic             speed_override,
    output logic      [15:0] speed_ref,
    output logic             brake_active,
    output logic      [15:0] brake_current,
    output logic             irq
);
    stop_state_type state_ff;
    stop_state_type nxt_state;

    logic [2:0]  c2_mode_ff;
    logic [2:0]  c3_mode_ff;
    logic [2:0]  ot_mode_ff;
    logic [15:0] fast_t_ff;
    logic [15:0] slow_t_ff;
    logic [15:0] brake_i_ff;
    logic [15:0] rated_ff;
    logic [EV_W-1:0] status_ff;
    logic [EV_W-1:0] mask_ff;
    logic [EV_W-1:0] events;
    logic [2:0]  rank_ff;
    logic [2:0]  mode_ff;
    logic [9:0]  last_code_ff;

    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;
    logic        motor_power_ff;
    logic        speed_override_ff;
    logic [15:0] speed_ref_ff;
    logic        brake_active_ff;
    logic [15:0] brake_current_ff;
    logic        irq_ff;

    logic        is_c1;
    logic        is_c2;
    logic        is_c3;
    logic [2:0]  cand_rank;
    logic [2:0]  cand_mode;
    logic        take;
    logic        addr_phase;
    logic        rd_status;
    logic [31:0] rd_value;
    logic [15:0] wdata;
    logic        mode_slow;
    logic        mode_keep;
    logic        ramp_load;
    logic [15:0] ramp_speed;
    logic        ramp_zero;

    assign hrdata         = hrdata_ff;
    assign hreadyout      = hreadyout_ff;
    assign hresp          = 1'b0;
    assign motor_power    = motor_power_ff;
    assign speed_override = speed_override_ff;
    assign speed_ref      = speed_ref_ff;
    assign brake_active   = brake_active_ff;
    assign brake_current  = brake_current_ff;
    assign irq            = irq_ff;

    // Fault classification by code range.
    assign is_c1 = fault_valid && fault_code >= CLASS1_LO && fault_code <= CLASS1_HI;
    assign is_c2 = fault_valid && fault_code >= CLASS2_LO && fault_code <= CLASS2_HI;
    assign is_c3 = fault_valid && fault_code >= CLASS3_LO && fault_code <= CLASS3_HI;

    always_comb begin
        cand_rank = RANK_NONE;
        cand_mode = MODE_COAST;
        if (is_c3) begin
            cand_rank = RANK_C3;
            cand_mode = c3_mode_ff;
        end
        if (overtravel) begin
            cand_rank = RANK_OT;
            cand_mode = ot_mode_ff;
        end
        if (is_c2) begin
            cand_rank = RANK_C2;
            cand_mode = c2_mode_ff;
        end
        if (is_c1) begin
            cand_rank = RANK_C1;
            cand_mode = MODE_COAST;
        end
    end

    // A repeated class one fault is taken again, so a clear in the same cycle cannot restart.
    assign take = (cand_rank > rank_ff) || is_c1;

    assign mode_slow = (mode_ff == MODE_SLOW_OFF) || (mode_ff == MODE_SLOW_HOLD);
    assign mode_keep = (mode_ff == MODE_FAST_HOLD) || (mode_ff == MODE_SLOW_HOLD);
    assign ramp_load = take && cand_mode != MODE_COAST && cand_mode != MODE_BRAKE;

    always_comb begin
        nxt_state = state_ff;
        if (take) begin
            if (cand_mode == MODE_COAST) begin
                nxt_state = ST_COAST;
            end else if (cand_mode == MODE_BRAKE) begin
                nxt_state = ST_BRAKE;
            end else begin
                nxt_state = ST_RAMP;
            end
        end else begin
            case (state_ff)
                ST_RUN: begin
                    nxt_state = ST_RUN;
                end
                ST_RAMP: begin
                    if (ramp_zero) begin
                        nxt_state = mode_keep ? ST_HOLD : ST_COAST;
                    end
                end
                ST_HOLD: begin
                    if (fault_clear) begin
                        nxt_state = ST_RUN;
                    end else if (!enable_in) begin
                        nxt_state = ST_COAST;
                    end
                end
                ST_BRAKE: begin
                    if (speed_fb == 16'h0000) begin
                        nxt_state = ST_COAST;
                    end
                end
                ST_COAST: begin
                    if (fault_clear) begin
                        nxt_state = ST_RUN;
                    end
                end
                default: begin
                    nxt_state = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff     <= ST_RUN;
            rank_ff      <= RANK_NONE;
            mode_ff      <= MODE_COAST;
            last_code_ff <= 10'h000;
        end else begin
            state_ff <= nxt_state;
            if (take) begin
                rank_ff      <= cand_rank;
                mode_ff      <= cand_mode;
                last_code_ff <= fault_code;
            end else if (nxt_state == ST_RUN) begin
                rank_ff <= RANK_NONE;
            end
        end
    end

    // ramp scaled by speed at fault
    decel_ramp u_ramp (
        .clock       (clock),
        .rst         (rst),
        .load        (ramp_load),
        .start_speed (state_ff == ST_RAMP ? ramp_speed : speed_fb),
        .run         (state_ff == ST_RAMP),
        .time_ms     ((take ? (cand_mode == MODE_SLOW_OFF || cand_mode == MODE_SLOW_HOLD)
                            : mode_slow) ? slow_t_ff : fast_t_ff),
        .rated_speed (rated_ff),
        .speed       (ramp_speed),
        .at_zero     (ramp_zero)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            motor_power_ff    <= 1'b0;
            speed_override_ff <= 1'b0;
            speed_ref_ff      <= 16'h0000;
            brake_active_ff   <= 1'b0;
            brake_current_ff  <= 16'h0000;
        end else begin
            motor_power_ff    <= (nxt_state == ST_RAMP) || (nxt_state == ST_HOLD) ||
                                 (nxt_state == ST_BRAKE) || (nxt_state == ST_RUN && enable_in);
            speed_override_ff <= (nxt_state == ST_RAMP) || (nxt_state == ST_HOLD);
            speed_ref_ff      <= (state_ff == ST_RAMP) ? ramp_speed : 16'h0000;
            brake_active_ff   <= (nxt_state == ST_BRAKE);
            brake_current_ff  <= (nxt_state == ST_BRAKE) ? brake_i_ff : 16'h0000;
        end
    end

    // Bus slave: zero wait states, read data registered at the address phase.
    assign addr_phase = hsel && hready && htrans[1];
    assign rd_status  = addr_phase && !hwrite && haddr[7:0] == OFF_STATUS;
    assign wdata      = hwdata[15:0];

    always_comb begin
        rd_value = 32'h0000_0000;
        case (haddr[7:0])
            OFF_C2_MODE: rd_value = {29'h0, c2_mode_ff};
            OFF_C3_MODE: rd_value = {29'h0, c3_mode_ff};
            OFF_OT_MODE: rd_value = {29'h0, ot_mode_ff};
            OFF_FAST_T:  rd_value = {16'h0, fast_t_ff};
            OFF_SLOW_T:  rd_value = {16'h0, slow_t_ff};
            OFF_BRAKE_I: rd_value = {16'h0, brake_i_ff};
            OFF_RATED:   rd_value = {16'h0, rated_ff};
            OFF_STATUS:  rd_value = {27'h0, status_ff};
            OFF_MASK:    rd_value = {27'h0, mask_ff};
            OFF_STATE:   rd_value = {14'h0, last_code_ff, rank_ff, state_ff};
            default:     rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_pend_ff   <= 1'b0;
            wr_addr_ff   <= 8'h00;
            hrdata_ff    <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff   <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_ff <= haddr[7:0];
                hrdata_ff  <= hwrite ? 32'h0000_0000 : rd_value;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            c2_mode_ff <= RST_MODE[2:0];
            c3_mode_ff <= RST_MODE[2:0];
            ot_mode_ff <= RST_MODE[2:0];
            fast_t_ff  <= RST_FAST_T;
            slow_t_ff  <= RST_SLOW_T;
            brake_i_ff <= RST_BRAKE_I;
            rated_ff   <= RST_RATED;
            mask_ff    <= {EV_W{1'b0}};
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                OFF_C2_MODE: if (wdata <= 16'(MODE_BRAKE)) c2_mode_ff <= wdata[2:0];
                OFF_C3_MODE: if (wdata <= 16'(MODE_BRAKE)) c3_mode_ff <= wdata[2:0];
                OFF_OT_MODE: if (wdata <= 16'(MODE_BRAKE)) ot_mode_ff <= wdata[2:0];
                OFF_FAST_T:  fast_t_ff  <= wdata;
                OFF_SLOW_T:  slow_t_ff  <= wdata;
                OFF_BRAKE_I: brake_i_ff <= wdata;
                OFF_RATED:   rated_ff   <= wdata;
                OFF_MASK:    mask_ff    <= wdata[EV_W-1:0];
                default:     mask_ff    <= mask_ff;
            endcase
        end
    end

    // Sticky events; a new event wins over the clearing read.
    always_comb begin
        events          = {EV_W{1'b0}};
        events[EV_C1]   = is_c1;
        events[EV_C2]   = is_c2;
        events[EV_C3]   = is_c3;
        events[EV_OT]   = overtravel;
        events[EV_DONE] = (state_ff == ST_RAMP || state_ff == ST_BRAKE) &&
                          (nxt_state == ST_HOLD || nxt_state == ST_COAST);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            status_ff <= {EV_W{1'b0}};
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= (rd_status ? {EV_W{1'b0}} : status_ff) | events;
            irq_ff    <= |(((rd_status ? {EV_W{1'b0}} : status_ff) | events) & mask_ff);
        end
    end

    a_class1_coast: assert property (@(posedge clock) disable iff (rst)
        is_c1 |=> state_ff == ST_COAST && !motor_power_ff)
        else $error("class one fault did not cut power");
    a_class2_select: assert property (@(posedge clock) disable iff (rst)
        take && is_c2 |=> mode_ff == $past(c2_mode_ff))
        else $error("class two fault ignored its mode");
    a_class3_select: assert property (@(posedge clock) disable iff (rst)
        take && is_c3 && !is_c2 && !is_c1 && !overtravel |=> mode_ff == $past(c3_mode_ff))
        else $error("class three fault ignored its mode");
    a_overtravel_select: assert property (@(posedge clock) disable iff (rst)
        take && overtravel && !fault_valid |=> mode_ff == $past(ot_mode_ff))
        else $error("over-travel ignored its mode");
    a_ramp_energised: assert property (@(posedge clock) disable iff (rst)
        state_ff == ST_RAMP |-> motor_power_ff && speed_override_ff)
        else $error("motor not energised during ramp");
    a_ramp_end_off: assert property (@(posedge clock) disable iff (rst)
        state_ff == ST_RAMP && ramp_zero && !take && !mode_keep |=> !motor_power_ff)
        else $error("drive not disabled after ramp");
    a_hold_release: assert property (@(posedge clock) disable iff (rst)
        state_ff == ST_HOLD && !enable_in && !take && !fault_clear |=> !motor_power_ff)
        else $error("hold did not release on enable drop");
    a_brake_current: assert property (@(posedge clock) disable iff (rst)
        take && cand_mode == MODE_BRAKE |=>
            brake_active_ff && brake_current_ff == $past(brake_i_ff))
        else $error("braking current not applied");
    a_mode_range: assert property (@(posedge clock) disable iff (rst)
        c2_mode_ff <= MODE_BRAKE && c3_mode_ff <= MODE_BRAKE && ot_mode_ff <= MODE_BRAKE)
        else $error("stop mode out of range");
    a_severity_keep: assert property (@(posedge clock) disable iff (rst)
        rank_ff == RANK_C1 && !fault_clear |=> rank_ff == RANK_C1)
        else $error("lower class overrode class one");

endmodule // servo_fault_stop_sequencer

// file: stop_seq_pkg.sv
package stop_seq_pkg;

    // Clock and timing.
    localparam int CLOCK_HZ      = 20_000_000;
    localparam int MS_PER_S      = 1000;
    localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_S;

    // Fault code ranges, held as plain binary numbers.
    localparam logic [9:0] CLASS1_LO = 10'd100;
    localparam logic [9:0] CLASS1_HI = 10'd199;
    localparam logic [9:0] CLASS2_LO = 10'd200;
    localparam logic [9:0] CLASS2_HI = 10'd599;
    localparam logic [9:0] CLASS3_LO = 10'd600;
    localparam logic [9:0] CLASS3_HI = 10'd999;

    // Stop modes.
    localparam logic [2:0] MODE_COAST     = 3'h0;
    localparam logic [2:0] MODE_FAST_OFF  = 3'h1;
    localparam logic [2:0] MODE_SLOW_OFF  = 3'h2;
    localparam logic [2:0] MODE_FAST_HOLD = 3'h3;
    localparam logic [2:0] MODE_SLOW_HOLD = 3'h4;
    localparam logic [2:0] MODE_BRAKE     = 3'h5;

    // Severity ranks, higher wins.
    localparam logic [2:0] RANK_NONE = 3'h0;
    localparam logic [2:0] RANK_C3   = 3'h1;
    localparam logic [2:0] RANK_OT   = 3'h2;
    localparam logic [2:0] RANK_C2   = 3'h3;
    localparam logic [2:0] RANK_C1   = 3'h4;

    // Register byte offsets.
    localparam logic [7:0] OFF_C2_MODE  = 8'h00;
    localparam logic [7:0] OFF_C3_MODE  = 8'h04;
    localparam logic [7:0] OFF_OT_MODE  = 8'h08;
    localparam logic [7:0] OFF_FAST_T   = 8'h0c;
    localparam logic [7:0] OFF_SLOW_T   = 8'h10;
    localparam logic [7:0] OFF_BRAKE_I  = 8'h14;
    localparam logic [7:0] OFF_RATED    = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1c;
    localparam logic [7:0] OFF_MASK     = 8'h20;
    localparam logic [7:0] OFF_STATE    = 8'h24;

    // Reset values.
    localparam logic [15:0] RST_MODE    = 16'h0000;
    localparam logic [15:0] RST_FAST_T  = 16'h01f4;
    localparam logic [15:0] RST_SLOW_T  = 16'h03e8;
    localparam logic [15:0] RST_BRAKE_I = 16'h0000;
    localparam logic [15:0] RST_RATED   = 16'h0bb8;

    // Event bits of the status and mask registers.
    localparam int EV_W     = 5;
    localparam int EV_C1    = 0;
    localparam int EV_C2    = 1;
    localparam int EV_C3    = 2;
    localparam int EV_OT    = 3;
    localparam int EV_DONE  = 4;

    typedef enum logic [4:0] {
        ST_RUN   = 5'b00001,
        ST_COAST = 5'b00010,
        ST_RAMP  = 5'b00100,
        ST_HOLD  = 5'b01000,
        ST_BRAKE = 5'b10000
    } stop_state_type;

endpackage

// file: test_servo_fault_stop_sequencer.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_servo_fault_stop_sequencer
    import stop_seq_pkg::*;
;
    localparam int LIMIT = 100000;
    logic        clock, rst, hsel, hwrite, hreadyout, hresp, fault_valid, overtravel;
    logic        enable_in, user_enable, fault_clear, motor_power, speed_override;
    logic        brake_active, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [9:0]  fault_code;
    logic [15:0] speed_fb, speed_ref, brake_current, user_speed, rnd;
    int          n_mismatch, checks_done, cycle_count;

    servo_fault_stop_sequencer dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_valid(fault_valid),
        .fault_code(fault_code), .overtravel(overtravel), .speed_fb(speed_fb),
        .enable_in(enable_in), .fault_clear(fault_clear), .motor_power(motor_power),
        .speed_override(speed_override), .speed_ref(speed_ref), .brake_active(brake_active),
        .brake_current(brake_current), .irq(irq));

    motor_stage_model motor_u (.clock(clock), .rst(rst), .motor_power(motor_power),
        .speed_override(speed_override), .speed_ref(speed_ref), .brake_active(brake_active),
        .user_speed(user_speed), .user_enable(user_enable), .speed_fb(speed_fb),
        .enable_in(enable_in));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [9:0] pick_code(input int cls, input logic [15:0] r);
        case (cls)
            0: return 10'(200 + r % 400);
            1: return 10'(600 + r % 400);
            default: return 10'(100 + r % 100);
        endcase
    endfunction

    function automatic logic [31:0] reset_value(input int i);
        case (i)
            3: return {16'h0, RST_FAST_T};
            4: return {16'h0, RST_SLOW_T};
            5: return {16'h0, RST_BRAKE_I};
            6: return {16'h0, RST_RATED};
            default: return {16'h0, RST_MODE};
        endcase
    endfunction

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do
            @(posedge clock);
        while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwrite <= 1'b0;
        if (w) hwdata <= d;
        do
            @(posedge clock);
        while (hreadyout !== 1'b1);
        r = hrdata;
        `CHK(hreadyout, 1'b1)
        `CHK(hresp, 1'b0)
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus_xfer(1'b1, a, d, r);
        @(posedge clock);
    endtask

    task automatic fire(input int cls, input logic [15:0] r);
        fault_code <= pick_code(cls, r);
        if (cls == 2) overtravel <= 1'b1;
        else fault_valid <= 1'b1;
        @(posedge clock);
        fault_valid <= 1'b0;
        overtravel  <= 1'b0;
        @(posedge clock);
    endtask

    task automatic pulse_clear();
        fault_clear <= 1'b1;
        @(posedge clock);
        fault_clear <= 1'b0;
        repeat (3) @(posedge clock);
    endtask

    always @(posedge clock) begin
        cycle_count++;
        if (cycle_count == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] bc;
        logic        bad;
        logic        ok;
        int          n, expc, spd, t;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fault_valid = 1'b0;
        fault_code = 10'h000;
        overtravel = 1'b0;
        user_enable = 1'b1;
        fault_clear = 1'b0;
        user_speed = 16'h012c;
        rnd = 16'h0049;
        n_mismatch = 0;
        checks_done = 0;
        cycle_count = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 7; i++) begin
            bus_xfer(1'b0, 8'(4 * i), 32'h0, r);
            `CHK(r, reset_value(i))
        end
        bus_xfer(1'b0, 8'h30, 32'h0, r);
        `CHK(r, 32'h0)
        reg_wr(OFF_FAST_T, 32'h1);
        reg_wr(OFF_SLOW_T, 32'h2);
        reg_wr(OFF_MASK, 32'h2);
        rnd = lfsr(rnd);
        bc = rnd | 16'h0001;
        reg_wr(OFF_BRAKE_I, {16'h0, bc});
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 6; m++) begin
                reg_wr(8'(4 * c), 32'(m));
                rnd = lfsr(rnd);
                spd = 150 + int'(rnd[7:0]);
                user_speed <= 16'(spd);
                repeat (3) @(posedge clock);
                fire(c, rnd);
                if (m != 5) `CHK(motor_power, 1'(m >= 1 && m <= 4))
                `CHK(speed_override, 1'(m >= 1 && m <= 4))
                `CHK(brake_active, 1'(m == 5))
                if (m == 5) begin
                    `CHK(brake_current, bc)
                    n = 0;
                    while (brake_active === 1'b1 && n < 3000) begin
                        @(posedge clock);
                        n++;
                    end
                    @(posedge clock);
                    `CHK(motor_power, 1'b0)
                end
                if (m >= 1 && m <= 4) begin
                    t = (m == 1 || m == 3) ? 1 : 2;
                    expc = t * CYCLES_PER_MS * spd / int'(RST_RATED);
                    n = 1;
                    bad = 1'b0;
                    do begin
                        @(posedge clock);
                        n++;
                        if (speed_ref !== 16'h0 && motor_power !== 1'b1) bad = 1'b1;
                        if (speed_ref > 16'(spd)) bad = 1'b1;
                    end while ((n < 5 || speed_ref !== 16'h0) && n < 3 * expc);
                    `CHK(bad, 1'b0)
                    ok = (n >= expc * 9 / 10) && (n <= expc * 11 / 10 + 20);
                    `CHK(ok, 1'b1)
                    repeat (3) @(posedge clock);
                    `CHK(motor_power, 1'(m >= 3))
                    if (m >= 3) begin
                        user_enable <= 1'b0;
                        repeat (3) @(posedge clock);
                        `CHK(motor_power, 1'b0)
                        user_enable <= 1'b1;
                    end
                end
                repeat (2) @(posedge clock);
                `CHK(irq, 1'(c == 0))
                bus_xfer(1'b0, OFF_STATUS, 32'h0, r);
                `CHK(r[3:0], 4'(1 << (c + 1)))
                repeat (2) @(posedge clock);
                `CHK(irq, 1'b0)
                pulse_clear();
                `CHK(motor_power, 1'b1)
            end
        end
        // A lower class is refused mid-ramp, then class one overrides the ramp.
        reg_wr(OFF_C2_MODE, 32'h1);
        user_speed <= 16'h0190;
        repeat (3) @(posedge clock);
        fire(0, rnd);
        fire(1, rnd);
        `CHK(speed_override, 1'b1)
        fire(3, rnd);
        `CHK(motor_power, 1'b0)
        `CHK(speed_override, 1'b0)
        bus_xfer(1'b0, OFF_STATUS, 32'h0, r);
        `CHK(r[2:0], 3'h7)
        pulse_clear();
        reg_wr(OFF_C2_MODE, 32'h6);
        bus_xfer(1'b0, OFF_C2_MODE, 32'h0, r);
        `CHK(r, 32'h1)
        bus_xfer(1'b0, OFF_STATE, 32'h0, r);
        `CHK(r, {14'h0, pick_code(3, rnd), RANK_NONE, ST_RUN})
        complete_run();
    end
endmodule // test_servo_fault_stop_sequencer
